// File: src/sdtx_pkg.sv
// constants, register map and types for the sdlc transmit modem and fifo control block
package sdtx_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [4:0] OFS_TX_CONTROL   = 5'h00;
	localparam logic [4:0] OFS_MISC_LINE    = 5'h04;
	localparam logic [4:0] OFS_EXT_FEATURE  = 5'h08;
	localparam logic [4:0] OFS_MODE         = 5'h0c;
	localparam logic [4:0] OFS_COMMAND      = 5'h10;
	localparam logic [4:0] OFS_TX_DATA      = 5'h14;
	localparam logic [4:0] OFS_PRIM_STATUS  = 5'h18;
	// tx_control_reg fields
	localparam int CTL_CRC_EN   = 0;
	localparam int CTL_SEND_REQ = 1;
	localparam int CTL_TX_EN    = 3;
	// misc_line_control_reg fields
	localparam int MISC_FLAG_UNDERRUN = 2;
	localparam int MISC_MARK_IDLE     = 3;
	localparam int MISC_ENC_LO        = 5;
	localparam int MISC_ENC_HI        = 6;
	localparam int MISC_CRC_PRESET    = 7;
	// extended_feature_reg fields
	localparam int EXT_AUTO_FLAG   = 0;
	localparam int EXT_AUTO_EOM    = 1;
	localparam int EXT_AUTO_RTS    = 2;
	localparam int EXT_FIFO_MODE   = 5;
	// mode register fields
	localparam int MODE_SDLC     = 0;
	localparam int MODE_AUTO_EN  = 1;
	localparam int MODE_DMA_EN   = 2;
	// command register fields, write-one strobes
	localparam int CMD_RESET_EOM = 0;
	localparam int CMD_RESET_CRC = 1;
	localparam int CMD_ABORT     = 2;
	// primary_status_reg fields
	localparam int ST_TX_REQ = 0;
	localparam int ST_TBE    = 2;
	localparam int ST_CTS    = 5;
	localparam int ST_EOM    = 6;
	localparam int ST_EMPTY  = 7;
	// reset values
	localparam logic [7:0] RST_TX_CONTROL = 8'h00;
	localparam logic [7:0] RST_MISC_LINE  = 8'h00;
	localparam logic [7:0] RST_EXT        = 8'h20;
	localparam logic [7:0] RST_MODE       = 8'h01;
	// line patterns and sizes
	localparam logic [7:0]  PAT_FLAG  = 8'h7e;
	localparam logic [7:0]  PAT_ONES  = 8'hff;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [4:0]  BITS_BYTE = 5'h08;
	localparam logic [4:0]  BITS_CRC  = 5'h10;
	localparam logic [2:0]  MAX_ONES  = 3'h5;
	localparam int          FIFO_DEPTH = 4;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// kind of unit currently held in the shift register
	typedef enum logic [2:0] {U_MARK, U_FLAG, U_DATA, U_CRC, U_ABORT} sdtx_unit_type;
endpackage : sdtx_pkg

// File: src/sdtx_fifo.sv
// four-entry transmit byte fifo with registered head data
`timescale 1ns/1ps
`default_nettype none
module sdtx_fifo (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_push,
	input  wire logic [7:0] i_data,
	input  wire logic       i_pop,
	input  wire logic       i_flush,
	output logic [7:0]      o_head,
	output logic            o_full,
	output logic            o_empty
);
	typedef struct packed {
		logic [3:0][7:0] mem;
		logic [1:0]      wr;
		logic [1:0]      rd;
		logic [2:0]      cnt;
		logic [7:0]      head;
	} sdtx_fifo_type;
	sdtx_fifo_type st_q, st_d;

	// next state; head is re-read from the updated array so it is never stale
	always_comb begin
		st_d = st_q;
		if (i_flush) begin
			st_d.wr  = st_q.rd;
			st_d.cnt = 3'h0;
		end else begin
			if (i_pop && st_q.cnt != 3'h0) begin
				st_d.rd  = st_q.rd + 2'h1;
				st_d.cnt = st_d.cnt - 3'h1;
			end
			if (i_push && st_q.cnt != 3'(sdtx_pkg::FIFO_DEPTH)) begin
				st_d.mem[st_q.wr] = i_data;
				st_d.wr  = st_q.wr + 2'h1;
				st_d.cnt = st_d.cnt + 3'h1;
			end
		end
		st_d.head = st_d.mem[st_d.rd];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_head  = st_q.head;
	assign o_full  = (st_q.cnt == 3'(sdtx_pkg::FIFO_DEPTH));
	assign o_empty = (st_q.cnt == 3'h0);
endmodule : sdtx_fifo
`default_nettype wire

// File: src/sdtx_crc.sv
// serial crc-ccitt generator with preset to ones or zeros
`timescale 1ns/1ps
`default_nettype none
module sdtx_crc (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_preset,
	input  wire logic        i_preset_ones,
	input  wire logic        i_shift,
	input  wire logic        i_bit,
	output logic [15:0]      o_crc
);
	typedef struct packed {
		logic [15:0] crc;
	} sdtx_crc_type;
	sdtx_crc_type st_q, st_d;

	// preset wins over a shift in the same cycle
	always_comb begin
		st_d = st_q;
		if (i_preset) begin
			st_d.crc = i_preset_ones ? 16'hffff : 16'h0000;
		end else if (i_shift) begin
			st_d.crc = {st_q.crc[14:0], 1'b0} ^ ((i_bit ^ st_q.crc[15]) ? sdtx_pkg::CRC_POLY : 16'h0000);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_crc = st_q.crc;
endmodule : sdtx_crc
`default_nettype wire

// File: src/sdtx_top.sv
// sdlc transmitter: modem lines, transmit fifo control, framing and axi4-lite registers
// How it works
// R1 - send-request pin is inverse of control bit
// R2 - auto-enable: clear-to-send high disables transmitter
// R3 - four byte fifo ahead of shift register
// R4 - fifo-mode bit resets to one, full-empty requests
// R5 - buffer-empty flag follows entry location only
// R6 - entry mode: request while entry location empty
// R7 - entry mode: dma request gaps after each byte
// R8 - host arms edge-triggered dma before enabling
// R9 - pending crc beats new data
// R10 - late write keeps buffer-empty flag cleared
// R11 - auto reset of latch and crc per packet
// R12 - mark idle sends ones, closing flag intact
// R13 - auto flag sends opening flag from mark idle
// R14 - idle ones shift eight at a time
// R15 - auto deactivation waits for closing flag last bit
// R16 - without flag-on-underrun, wait for next flag
// R17 - non-sdlc modes follow send-request bit immediately
// R18 - nrzi mark idle forces line high after flag
// R19 - forcing applies on every path into mark idle
// R20 - forcing off when mark idle is cleared
// R21 - software clears mark idle without auto flag
// R22 - write into entry location clears buffer-empty flag
// R23 - crc or abort load sets end-of-message latch
// R24 - setting send-request again cancels pending deassertion
`timescale 1ns/1ps
`default_nettype none
module sdtx_top (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_awaddr,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	output logic [1:0]       o_s_axi_bresp,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	input  wire logic [31:0] i_s_axi_araddr,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	input  wire logic        i_tx_bit_clock,
	input  wire logic        i_clear_to_send_n,
	output logic             o_tx_data,
	output logic             o_send_request_n,
	output logic             o_tx_empty_req,
	output logic             o_tx_dma_req_n
);
	typedef struct packed {
		logic [7:0]                 ctl;
		logic [7:0]                 misc;
		logic [7:0]                 ext;
		logic [7:0]                 mode;
		logic                       aw_have;
		logic [4:0]                 aw_addr;
		logic                       w_have;
		logic [7:0]                 w_data;
		logic                       w_lane0;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [7:0]                 rdata;
		logic [1:0]                 rresp;
		logic [2:0]                 tclk;
		logic [1:0]                 cts;
		sdtx_pkg::sdtx_unit_type    unit;
		logic                       live;
		logic [15:0]                shift;
		logic [4:0]                 left;
		logic [2:0]                 ones;
		logic                       line;
		logic                       end_of_message_latch;
		logic                       closing;
		logic                       abort_req;
		logic                       rts;
		logic                       rts_pend;
		logic                       pushed;
	} sdtx_top_type;
	sdtx_top_type st_q, st_d;

	logic [1:0]  rst_q;
	logic        rst_n;
	logic [7:0]  fifo_head;
	logic        fifo_full;
	logic        fifo_empty;
	logic        fifo_push;
	logic        fifo_pop;
	logic        fifo_flush;
	logic [15:0] crc_val;
	logic        crc_preset;
	logic        crc_shift;
	logic        crc_bit;

	// release of the asynchronous reset passes two flops
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	sdtx_fifo u_fifo (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_push  (fifo_push),
		.i_data  (st_q.w_data),
		.i_pop   (fifo_pop),
		.i_flush (fifo_flush),
		.o_head  (fifo_head),
		.o_full  (fifo_full),
		.o_empty (fifo_empty)
	);

	sdtx_crc u_crc (
		.i_clk         (i_clk),
		.i_rst_n       (rst_n),
		.i_preset      (crc_preset),
		.i_preset_ones (st_q.misc[sdtx_pkg::MISC_CRC_PRESET]),
		.i_shift       (crc_shift),
		.i_bit         (crc_bit),
		.o_crc         (crc_val)
	);

	// decoded modes and link events; edges come from the second and third sync stage only
	logic tx_fall;
	logic tx_rise;
	logic sdlc;
	logic nrzi;
	logic mark_idle;
	logic tx_go;
	logic wr_fire;
	logic ent_empty;
	logic tx_req;
	logic flag_done;
	assign tx_fall   = st_q.tclk[2] & ~st_q.tclk[1];
	assign tx_rise   = ~st_q.tclk[2] & st_q.tclk[1];
	assign sdlc      = st_q.mode[sdtx_pkg::MODE_SDLC];
	assign nrzi      = ~st_q.misc[sdtx_pkg::MISC_ENC_HI] & st_q.misc[sdtx_pkg::MISC_ENC_LO];
	assign mark_idle = st_q.misc[sdtx_pkg::MISC_MARK_IDLE];
	// auto-enable gates only the start of a unit, so a unit in flight completes
	assign tx_go     = st_q.ctl[sdtx_pkg::CTL_TX_EN]
	                 & ~(st_q.mode[sdtx_pkg::MODE_AUTO_EN] & st_q.cts[1]);             // [R2]
	assign wr_fire   = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
	assign ent_empty = ~fifo_full;                                                    // [R5] [R10] [R22]
	// fifo mode waits for the whole fifo, entry mode only for the entry slot
	assign tx_req    = st_q.ext[sdtx_pkg::EXT_FIFO_MODE] ? fifo_empty : ent_empty;   // [R4] [R6]
	assign flag_done = tx_rise & st_q.live & (st_q.unit == sdtx_pkg::U_FLAG) & (st_q.left == 5'h00);

	// bus handshakes are combinational; one write and one read in flight
	assign o_s_axi_awready = ~st_q.aw_have & ~st_q.bvalid;
	assign o_s_axi_wready  = ~st_q.w_have & ~st_q.bvalid;
	assign o_s_axi_arready = ~st_q.rvalid;
	assign fifo_push  = wr_fire & st_q.w_lane0 & (st_q.aw_addr == sdtx_pkg::OFS_TX_DATA);  // [R3]
	assign fifo_flush = wr_fire & st_q.w_lane0 & (st_q.aw_addr == sdtx_pkg::OFS_COMMAND)
	                  & st_q.w_data[sdtx_pkg::CMD_ABORT];

	// transmit unit selection and bit shifting; crc hooks are combinational into the generator
	always_comb begin
		logic       load;
		logic       out_bit;
		logic       stuff;
		logic [7:0] rd;
		load       = 1'b0;
		out_bit    = 1'b1;
		stuff      = 1'b0;
		rd         = 8'h00;
		fifo_pop   = 1'b0;
		crc_preset = 1'b0;
		crc_shift  = 1'b0;
		crc_bit    = 1'b0;
		st_d       = st_q;
		st_d.tclk  = {st_q.tclk[1:0], i_tx_bit_clock};
		st_d.cts   = {st_q.cts[0], i_clear_to_send_n};
		st_d.pushed = fifo_push;

		// axi4-lite write path: address and data taken in either order
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = i_s_axi_awaddr[4:0];
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			st_d.w_have  = 1'b1;
			st_d.w_data  = i_s_axi_wdata[7:0];
			st_d.w_lane0 = i_s_axi_wstrb[0];
		end
		if (wr_fire) begin
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = sdtx_pkg::RESP_OKAY;
			case (st_q.aw_addr)
				sdtx_pkg::OFS_TX_CONTROL: if (st_q.w_lane0) st_d.ctl = st_q.w_data;
				sdtx_pkg::OFS_MISC_LINE: if (st_q.w_lane0) st_d.misc = st_q.w_data;
				sdtx_pkg::OFS_EXT_FEATURE: if (st_q.w_lane0) st_d.ext = st_q.w_data;
				sdtx_pkg::OFS_MODE: if (st_q.w_lane0) st_d.mode = st_q.w_data;   // dma enable: host arms first [R8]
				sdtx_pkg::OFS_COMMAND: begin
					if (st_q.w_lane0 && st_q.w_data[sdtx_pkg::CMD_RESET_EOM]) st_d.end_of_message_latch = 1'b0;
					if (st_q.w_lane0 && st_q.w_data[sdtx_pkg::CMD_RESET_CRC]) crc_preset = 1'b1;
					if (st_q.w_lane0 && st_q.w_data[sdtx_pkg::CMD_ABORT]) st_d.abort_req = 1'b1;
				end
				sdtx_pkg::OFS_TX_DATA: st_d.bresp = sdtx_pkg::RESP_OKAY;
				default: st_d.bresp = sdtx_pkg::RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && i_s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		// axi4-lite read path, answer one cycle after the address is taken
		if (i_s_axi_arvalid && o_s_axi_arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = sdtx_pkg::RESP_OKAY;
			case (i_s_axi_araddr[4:0])
				sdtx_pkg::OFS_TX_CONTROL: rd = st_q.ctl;
				sdtx_pkg::OFS_MISC_LINE: rd = st_q.misc;
				sdtx_pkg::OFS_EXT_FEATURE: rd = st_q.ext;
				sdtx_pkg::OFS_MODE: rd = st_q.mode;
				sdtx_pkg::OFS_PRIM_STATUS: begin
					rd[sdtx_pkg::ST_TX_REQ] = tx_req;
					rd[sdtx_pkg::ST_TBE]    = ent_empty;
					rd[sdtx_pkg::ST_CTS]    = ~st_q.cts[1];
					rd[sdtx_pkg::ST_EOM]    = st_q.end_of_message_latch;
					rd[sdtx_pkg::ST_EMPTY]  = fifo_empty;
				end
				sdtx_pkg::OFS_COMMAND, sdtx_pkg::OFS_TX_DATA: rd = 8'h00;
				default: st_d.rresp = sdtx_pkg::RESP_SLVERR;
			endcase
			st_d.rdata = rd;
		end else if (st_q.rvalid && i_s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end

		// last bit of a unit has left the line
		if (tx_rise && st_q.live && st_q.left == 5'h00) begin
			st_d.live = 1'b0;
		end

		// falling link clock: pick a new unit when the old one is spent, then drive one bit
		if (tx_fall) begin
			if (!st_q.live || st_q.left == 5'h00) begin
				if (tx_go) begin
					load = 1'b1;
					st_d.live    = 1'b1;
					st_d.closing = 1'b0;
					st_d.left    = sdtx_pkg::BITS_BYTE;
					st_d.ones    = 3'h0;
					if (st_q.abort_req) begin
						st_d.unit      = sdtx_pkg::U_ABORT;
						st_d.shift     = {8'h00, sdtx_pkg::PAT_ONES};
						st_d.abort_req = 1'b0;
						st_d.end_of_message_latch       = 1'b1;                                      // [R23]
					end else if (st_q.unit == sdtx_pkg::U_CRC || st_q.unit == sdtx_pkg::U_ABORT) begin
						st_d.unit    = sdtx_pkg::U_FLAG;
						st_d.shift   = {8'h00, sdtx_pkg::PAT_FLAG};
						st_d.closing = 1'b1;
					end else if (st_q.unit == sdtx_pkg::U_DATA && fifo_empty) begin
						// underrun: closing flag if the end-of-message latch is set, abort with flag-on-underrun, else crc before any new byte [R9]
						if (st_q.end_of_message_latch) begin
							st_d.unit    = sdtx_pkg::U_FLAG;
							st_d.shift   = {8'h00, sdtx_pkg::PAT_FLAG};
							st_d.closing = 1'b1;
						end else if (st_q.misc[sdtx_pkg::MISC_FLAG_UNDERRUN]) begin
							st_d.unit  = sdtx_pkg::U_ABORT;
							st_d.shift = {8'h00, sdtx_pkg::PAT_ONES};
							st_d.end_of_message_latch   = 1'b1;                                      // [R23]
						end else begin
							st_d.unit  = sdtx_pkg::U_CRC;
							st_d.shift = crc_val;
							st_d.left  = sdtx_pkg::BITS_CRC;
							st_d.end_of_message_latch   = 1'b1;                                      // [R23]
						end
					end else if (!fifo_empty && (st_q.unit == sdtx_pkg::U_DATA || st_q.unit == sdtx_pkg::U_FLAG)) begin
						if (st_q.unit == sdtx_pkg::U_FLAG && st_q.ext[sdtx_pkg::EXT_AUTO_EOM]) begin
							st_d.end_of_message_latch   = 1'b0;                                      // [R11]
							crc_preset = 1'b1;                                      // [R11]
						end
						st_d.unit  = sdtx_pkg::U_DATA;
						st_d.shift = {8'h00, fifo_head};
						fifo_pop   = 1'b1;
					end else if (!fifo_empty && (!mark_idle || st_q.ext[sdtx_pkg::EXT_AUTO_FLAG])) begin
						st_d.unit  = sdtx_pkg::U_FLAG;                              // [R13]
						st_d.shift = {8'h00, sdtx_pkg::PAT_FLAG};
					end else if (mark_idle) begin
						// without auto flag, software must clear mark idle to start [R21]
						st_d.unit  = sdtx_pkg::U_MARK;                              // [R12] [R14]
						st_d.shift = {8'h00, sdtx_pkg::PAT_ONES};
					end else begin
						st_d.unit  = sdtx_pkg::U_FLAG;
						st_d.shift = {8'h00, sdtx_pkg::PAT_FLAG};
					end
				end else begin
					st_d.line = 1'b1;
				end
			end
			if (load || st_q.live && st_q.left != 5'h00) begin
				// crc and data are zero-stuffed; flags, aborts and idle ones are not
				stuff = (st_d.unit == sdtx_pkg::U_DATA || st_d.unit == sdtx_pkg::U_CRC);
				if (stuff && st_d.ones == sdtx_pkg::MAX_ONES) begin
					out_bit   = 1'b0;
					st_d.ones = 3'h0;
				end else begin
					if (st_d.unit == sdtx_pkg::U_CRC) begin
						out_bit    = st_d.shift[15];
						st_d.shift = {st_d.shift[14:0], 1'b0};
					end else begin
						out_bit    = st_d.shift[0];
						st_d.shift = {1'b0, st_d.shift[15:1]};
					end
					if (st_d.unit == sdtx_pkg::U_DATA) begin
						crc_shift = st_q.ctl[sdtx_pkg::CTL_CRC_EN];
						crc_bit   = out_bit;
					end
					st_d.ones = (stuff && out_bit) ? st_d.ones + 3'h1 : 3'h0;
					st_d.left = st_d.left - 5'h01;
				end
				st_d.line = nrzi ? (out_bit ? st_q.line : ~st_q.line) : out_bit;
				// going into mark idle with nrzi in sdlc mode: hold the line high on the last bit of a flag or abort
				if (sdlc && nrzi && mark_idle && fifo_empty && st_d.left == 5'h00
				    && (st_d.unit == sdtx_pkg::U_FLAG || st_d.unit == sdtx_pkg::U_ABORT)) begin
					st_d.line = 1'b1;                                               // [R18] [R19] [R20]
				end
			end
		end

		// send-request pin: immediate outside sdlc; inside sdlc delayed to the closing flag only with auto rts while a frame unit is live
		if (!sdlc) begin
			st_d.rts      = st_d.ctl[sdtx_pkg::CTL_SEND_REQ];                        // [R17]
			st_d.rts_pend = 1'b0;
		end else if (st_d.ctl[sdtx_pkg::CTL_SEND_REQ]) begin
			st_d.rts      = 1'b1;
			st_d.rts_pend = 1'b0;                                                    // [R24]
		end else if (st_q.rts && !st_q.rts_pend) begin
			if (st_q.ext[sdtx_pkg::EXT_AUTO_RTS] && st_q.live && st_q.unit != sdtx_pkg::U_MARK
			    && !(st_q.unit == sdtx_pkg::U_FLAG && !st_q.closing)) begin
				st_d.rts_pend = 1'b1;                                                // [R15]
			end else begin
				st_d.rts = 1'b0;
			end
		end else if (st_q.rts_pend && flag_done
		             && (st_q.closing || !st_q.misc[sdtx_pkg::MISC_FLAG_UNDERRUN])) begin
			st_d.rts      = 1'b0;                                                    // [R15] [R16]
			st_d.rts_pend = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= '0;
			st_q.ctl  <= sdtx_pkg::RST_TX_CONTROL;
			st_q.misc <= sdtx_pkg::RST_MISC_LINE;
			st_q.ext  <= sdtx_pkg::RST_EXT;                                          // [R4]
			st_q.mode <= sdtx_pkg::RST_MODE;
			st_q.unit <= sdtx_pkg::U_MARK;
			st_q.tclk <= 3'h0;
			st_q.cts  <= 2'h3;
			st_q.line <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs; dma request drops for a cycle after each byte in entry mode
	assign o_send_request_n = ~st_q.rts;                                             // [R1]
	assign o_tx_data        = st_q.line;
	assign o_tx_empty_req   = tx_req;
	assign o_tx_dma_req_n   = ~(st_q.mode[sdtx_pkg::MODE_DMA_EN] & tx_req & ~st_q.pushed);  // [R7]
	assign o_s_axi_bvalid   = st_q.bvalid;
	assign o_s_axi_bresp    = st_q.bresp;
	assign o_s_axi_rvalid   = st_q.rvalid;
	assign o_s_axi_rdata    = {24'h000000, st_q.rdata};
	assign o_s_axi_rresp    = st_q.rresp;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	chk_rts_pin_inverse: assert property (!sdlc |=> o_send_request_n == !$past(st_d.rts))  // [R1] [R17]
		else $error("send request pin not inverse of bit");
	chk_auto_enable_gate: assert property (tx_fall && st_q.mode[sdtx_pkg::MODE_AUTO_EN] && st_q.cts[1] // [R2]
		&& !st_q.live |=> !st_q.live)
		else $error("unit started while clear-to-send high");
	chk_fifo_mode_req: assert property (st_q.ext[sdtx_pkg::EXT_FIFO_MODE] && !fifo_empty |-> !o_tx_empty_req) // [R4]
		else $error("request in fifo mode with data queued");
	chk_entry_mode_req: assert property (!st_q.ext[sdtx_pkg::EXT_FIFO_MODE] |-> o_tx_empty_req == !fifo_full) // [R6]
		else $error("entry mode request wrong");
	chk_dma_gap: assert property (fifo_push |=> o_tx_dma_req_n)                        // [R7]
		else $error("dma request did not gap after byte");
	chk_eom_on_crc: assert property ($rose(st_q.live) && st_q.unit == sdtx_pkg::U_CRC |-> st_q.end_of_message_latch) // [R23]
		else $error("latch not set with crc load");
	chk_crc_whole: assert property (st_q.unit == sdtx_pkg::U_CRC && st_q.live && st_q.left != 5'h00 // [R9]
		|=> st_q.unit == sdtx_pkg::U_CRC)
		else $error("crc cut short by data");
	chk_rts_hold_pend: assert property (st_q.rts_pend && !flag_done && !st_d.ctl[sdtx_pkg::CTL_SEND_REQ] // [R15]
		&& sdlc |=> !o_send_request_n)
		else $error("send request dropped before flag end");
	chk_mark_high: assert property (tx_fall && st_q.unit == sdtx_pkg::U_MARK && st_q.live && !nrzi // [R12]
		|=> o_tx_data)
		else $error("mark idle not sending ones");
	chk_tbe_write: assert property ($rose(st_q.rvalid) && $past(fifo_full) // [R22]
		&& $past(i_s_axi_araddr[4:0] == sdtx_pkg::OFS_PRIM_STATUS) |-> !st_q.rdata[sdtx_pkg::ST_TBE])
		else $error("buffer-empty set while entry full");

	cov_crc_frame: cover property (st_q.unit == sdtx_pkg::U_DATA ##[1:300] st_q.unit == sdtx_pkg::U_CRC);
	cov_rts_delayed: cover property (st_q.rts_pend ##[1:300] !st_q.rts);
	cov_mark_force: cover property (sdlc && nrzi && mark_idle && st_q.unit == sdtx_pkg::U_MARK);
	cov_abort_cmd: cover property (fifo_flush);
endmodule : sdtx_top
`default_nettype wire

// File: test/sdtx_line_model.sv
// line-side partner: gated bit clock source and capture of the serial line
`timescale 1ns/1ps
`default_nettype none
module sdtx_line_model (
	input  wire logic i_run,
	input  wire logic i_line,
	output logic      o_bit_clock,
	output logic [7:0] o_seen
);
	// clock parks low while i_run is low so a free-running edge cannot hide a fault
	initial begin
		o_bit_clock = 1'b0;
		forever #400 o_bit_clock = i_run ? ~o_bit_clock : 1'b0;
	end
	// capture on the rising edge, lsb arrives first
	always @(posedge o_bit_clock) begin
		o_seen <= {i_line, o_seen[7:1]};
	end
endmodule : sdtx_line_model
`default_nettype wire

// File: test/sdtx_tb_top.sv
// testbench: register access, fifo requests, modem lines and idle patterns
`timescale 1ns/1ps
`default_nettype none
module sdtx_tb_top;
	logic        i_clk, i_nrst, awv, wv, arv, cts_n, run, e_req, dma_n, txd, rts_n, aw_r, w_r, ar_r, bv, rv, bclk;
	logic [31:0] adr, wd, rdat;
	logic [1:0]  bresp, rresp;
	logic [7:0]  seen;
	int          bad_count = 0, checked = 0, seed = 42202;
	sdtx_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_s_axi_awvalid(awv), .o_s_axi_awready(aw_r),
		.i_s_axi_awaddr(adr), .i_s_axi_wvalid(wv), .o_s_axi_wready(w_r), .i_s_axi_wdata(wd),
		.i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv), .i_s_axi_bready(1'b1), .o_s_axi_bresp(bresp),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(ar_r), .i_s_axi_araddr(adr), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(1'b1), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .i_tx_bit_clock(bclk),
		.i_clear_to_send_n(cts_n), .o_tx_data(txd), .o_send_request_n(rts_n),
		.o_tx_empty_req(e_req), .o_tx_dma_req_n(dma_n));
	sdtx_line_model mdl (.i_run(run), .i_line(txd), .o_bit_clock(bclk), .o_seen(seen));
	// 10 mhz system clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	// write: both channels offered together, each dropped when taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		awv <= 1'b1;
		wv <= 1'b1;
		adr <= {27'h0, a};
		wd <= {24'h0, d};
		do begin
			@(posedge i_clk);
			if (aw_r) awv <= 1'b0;
			if (w_r) wv <= 1'b0;
		end while (bv !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr
	// read and compare the masked low byte
	task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		arv <= 1'b1;
		adr <= {27'h0, a};
		do begin
			@(posedge i_clk);
			if (ar_r) arv <= 1'b0;
		end while (rv !== 1'b1);
		chk("rdata", e, rdat & m);
	endtask : rc
	// search a window of bit times for a byte pattern on the line
	task automatic look(input logic [7:0] e);
		logic hit;
		hit = 1'b0;
		repeat (40) @(posedge bclk) hit = hit | (seen === e);
		chk("line", 32'h1, {31'h0, hit});
		@(posedge i_clk);
	endtask : look
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	initial begin
		{awv, wv, arv, run, i_nrst, cts_n} = 6'h01;
		adr = 32'h0;
		wd = 32'h0;
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk);
		rc(sdtx_pkg::OFS_EXT_FEATURE, 32'h20, 32'hff);
		rc(sdtx_pkg::OFS_PRIM_STATUS, 32'h84, 32'h84);
		wr(sdtx_pkg::OFS_MODE, 8'h05, sdtx_pkg::RESP_OKAY);
		chk("empty_req", 32'h1, {31'h0, e_req});
		chk("dma_req_n", 32'h0, {31'h0, dma_n});
		wr(sdtx_pkg::OFS_TX_DATA, 8'($random(seed)), sdtx_pkg::RESP_OKAY);
		chk("empty_req", 32'h0, {31'h0, e_req});
		rc(sdtx_pkg::OFS_PRIM_STATUS, 32'h04, 32'h84);
		repeat (3) wr(sdtx_pkg::OFS_TX_DATA, 8'($random(seed)), sdtx_pkg::RESP_OKAY);
		rc(sdtx_pkg::OFS_PRIM_STATUS, 32'h00, 32'h84);
		wr(sdtx_pkg::OFS_COMMAND, 8'h04, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_EXT_FEATURE, 8'h00, sdtx_pkg::RESP_OKAY);
		repeat (2) wr(sdtx_pkg::OFS_TX_DATA, 8'($random(seed)), sdtx_pkg::RESP_OKAY);
		chk("empty_req", 32'h1, {31'h0, e_req});
		repeat (2) wr(sdtx_pkg::OFS_TX_DATA, 8'($random(seed)), sdtx_pkg::RESP_OKAY);
		chk("empty_req", 32'h0, {31'h0, e_req});
		wr(sdtx_pkg::OFS_COMMAND, 8'h04, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_PRIM_STATUS, 8'h00, sdtx_pkg::RESP_SLVERR);
		$display("test fifo done");
		// modem lines: send request follows the bit, clear-to-send feeds status
		wr(sdtx_pkg::OFS_MODE, 8'h00, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_TX_CONTROL, 8'h02, sdtx_pkg::RESP_OKAY);
		chk("rts_n", 32'h0, {31'h0, rts_n});
		wr(sdtx_pkg::OFS_TX_CONTROL, 8'h00, sdtx_pkg::RESP_OKAY);
		chk("rts_n", 32'h1, {31'h0, rts_n});
		cts_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		rc(sdtx_pkg::OFS_PRIM_STATUS, 32'h20, 32'h20);
		cts_n <= 1'b1;
		$display("test modem done");
		// line: auto enable holds it idle high, then flags, then mark idle
		wr(sdtx_pkg::OFS_MODE, 8'h03, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_MISC_LINE, 8'h00, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_TX_CONTROL, 8'h08, sdtx_pkg::RESP_OKAY);
		run <= 1'b1;
		look(8'hff);
		cts_n <= 1'b0;
		look(8'h7e);
		wr(sdtx_pkg::OFS_MISC_LINE, 8'h08, sdtx_pkg::RESP_OKAY);
		look(8'hff);
		$display("test line done");
		// one frame from mark idle; send request cleared mid-frame must wait for the closing flag
		wr(sdtx_pkg::OFS_EXT_FEATURE, 8'h05, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_TX_CONTROL, 8'h0a, sdtx_pkg::RESP_OKAY);
		wr(sdtx_pkg::OFS_TX_DATA, 8'($random(seed)), sdtx_pkg::RESP_OKAY);
		repeat (18) @(posedge bclk);
		// clear mid-bit so the unit is live when the write lands
		@(negedge bclk);
		repeat (2) @(posedge i_clk);
		wr(sdtx_pkg::OFS_TX_CONTROL, 8'h08, sdtx_pkg::RESP_OKAY);
		chk("rts_n", 32'h0, {31'h0, rts_n});
		repeat (24) @(posedge bclk);
		repeat (4) @(posedge i_clk);
		chk("rts_n", 32'h1, {31'h0, rts_n});
		chk("txd", 32'h1, {31'h0, txd});
		$display("test rts done");
		conclude();
	end
	// watchdog well past the expected run length
	initial begin
		#3000000;
		bad_count++;
		conclude();
	end
endmodule : sdtx_tb_top
`default_nettype wire
